/* dpha_pkg.sv */
// Constants, register map and state types of the two-port histogram engine.
// Assumes a single 40 MHz clock and a plain byte-addressed register port.
package dpha_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ  = 40;                  // Core clock rate
	localparam int XF075_NS = 750;                 // Transfer time choices
	localparam int XF100_NS = 1000;
	localparam int XF150_NS = 1500;
	localparam int XF200_NS = 2000;
	localparam int MEM_NS   = 1000;                // Read, add, write phase
	localparam int TICK_NS  = 10_000_000;          // Preset time resolution
	// Least times, so round up to whole cycles
	localparam int XF075_CYC = (XF075_NS * CLK_MHZ + 999) / 1000;
	localparam int XF100_CYC = (XF100_NS * CLK_MHZ + 999) / 1000;
	localparam int XF150_CYC = (XF150_NS * CLK_MHZ + 999) / 1000;
	localparam int XF200_CYC = (XF200_NS * CLK_MHZ + 999) / 1000;
	localparam int MEM_CYC   = (MEM_NS * CLK_MHZ + 999) / 1000;
	localparam int TICK_CYC  = (TICK_NS / 1000) * CLK_MHZ;

	// ----------------------------------------
	// Sizes and limits
	// ----------------------------------------
	localparam int          CHAN_W   = 16;               // 64K channel pool
	localparam logic [31:0] CNT_MAX  = 32'h7FFF_FFFF;    // Largest channel count
	localparam logic [7:0]  GLEN_MAX = 8'h80;            // 32K in 256 units

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_STAT  = 8'h04;
	localparam logic [7:0] A_ISTAT = 8'h08;
	localparam logic [7:0] A_IMASK = 8'h0C;
	localparam logic [7:0] A_MADDR = 8'h10;
	localparam logic [7:0] A_MDATA = 8'h14;
	localparam logic [1:0] A_PORT  = 2'h1;   // 0x40 + 0x20 * port
	localparam logic [2:0] A_CNT   = 3'h4;   // 0x80 + 0x10 * port
	// Per-port setup words
	localparam logic [2:0] P_BASE = 3'h0, P_GRP = 3'h1, P_WGT = 3'h2, P_PEN = 3'h3;
	localparam logic [2:0] P_LIVE = 3'h4, P_TRUE = 3'h5, P_ROI = 3'h6, P_ROIP = 3'h7;
	// Per-port elapsed counters
	localparam logic [1:0] C_LIVE = 2'h0, C_TRUE = 2'h1, C_ROI = 2'h2;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CT_ACQ = 0, CT_LFC = 2, CT_XS0 = 4, CT_XS1 = 6;
	localparam int ST_OVF = 0, ST_ACQ = 2;
	localparam int IR_DONE = 0, IR_OVF = 2;
	localparam int PE_LIVE = 0, PE_TRUE = 1, PE_ROI = 2, PE_OVF = 3;
	localparam logic [1:0] XSEL_RST = 2'h1;              // 1 us per port

	typedef enum logic [1:0] {P_IDLE, P_XFER, P_WAIT, P_RMW} dpha_pst_t;

endpackage

/* dpha_engine.sv */
// Two-port histogram acquisition engine with a shared 64K channel memory.
// Assumes converters hold ready with data until accept has come and gone.
`timescale 1ns/1ps
module dpha_engine
	import dpha_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC          // Shorten for simulation
)(
	input  wire logic                clk,
	input  wire logic                resetn,
	input  wire logic [7:0]          reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [31:0]         reg_rdata,
	input  wire logic [1:0][15:0]    channel_bit_lsb_n,
	input  wire logic [1:0]          conv_ready,
	output logic      [1:0]          conv_accept,
	output logic      [1:0]          port_collecting_lamp,
	output logic      [1:0]          port_active_lamp,
	output logic                     irq
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Group length in 256-channel units, capped at 32K
	function automatic logic [7:0] dpha_glen(input logic [7:0] l);
		return (l > GLEN_MAX) ? GLEN_MAX : l;
	endfunction

	// Memory address of a channel in the selected group
	function automatic logic [15:0] dpha_gaddr(input logic [15:0] b, input logic [13:0] g,
		input logic [15:0] c);
		logic [13:0] off;
		off = 14'(g[13:8] * dpha_glen(g[7:0]));
		return 16'(b + {off[7:0], 8'h00} + c);
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [31:0]    mem [0:(1 << CHAN_W) - 1];   // Shared channel pool
	logic [1:0]     acq;                          // Port acquiring
	logic [1:0]     loss_free_weighting;                          // Weighted mode per port
	logic [1:0]     xsel [2];                     // Transfer time choice
	logic [1:0]     ovf;                          // Port overflow flag
	logic [3:0]     ist, imsk;                    // Interrupt status, mask
	logic [15:0]    maddr;                        // Software memory pointer
	logic [15:0]    base [2];                     // Allocation start
	logic [13:0]    grp [2];                      // Group select and length
	logic [15:0]    wgt [2];                      // Weight N
	logic [3:0]     pen [2];                      // Preset enables
	logic [31:0]    lpre [2], tpre [2], rpre [2]; // Preset limits
	logic [31:0]    region_of_interest [2];                      // Region bounds hi:lo
	logic [31:0]    live [2], tru [2], rcnt [2];  // Elapsed counters
	dpha_pst_t      pst [2];                      // Port state
	logic [6:0]     xcnt [2];                     // Transfer countdown
	logic [15:0]    chan [2];                     // Captured channel
	logic           busy, own;                    // Memory phase, owner
	logic [5:0]     mcnt;                         // Memory phase count
	logic [15:0]    mwa;                          // Address being updated
	logic [31:0]    rdv;                          // Count read back
	logic [18:0]    tcnt;                         // Tick divider
	logic           tick;                         // 0.01 s pulse

	// Combinational terms
	logic           gnt_v, gnt_p, mem_we, ovf_hit;
	logic [15:0]    inc;
	logic [32:0]    sum;
	logic [31:0]    wdat;
	logic [1:0]     stop, start, ctl_wr;
	logic           pw;
	logic [1:0]     pp;

	// ----------------------------------------
	// Time base
	// ----------------------------------------
	// hundredth-second tick
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			tcnt <= '0;
			tick <= 1'b0;
		end
		else
		begin
			tick <= (tcnt == 19'(TICK_CYCLES - 1));
			tcnt <= (tcnt == 19'(TICK_CYCLES - 1)) ? '0 : tcnt + 19'h0_0001;
		end
	end

	// ----------------------------------------
	// Arbitration and update arithmetic
	// ----------------------------------------
	// Round robin so a busy port cannot starve the other
	always_comb
	begin
		gnt_v  = !busy && (pst[0] == P_WAIT || pst[1] == P_WAIT);
		gnt_p  = (pst[1] == P_WAIT) && (pst[0] != P_WAIT || !own);
		// write lands one memory phase after grant
		mem_we = busy && (mcnt == 6'(MEM_CYC - 2));
		inc    = loss_free_weighting[own] ? wgt[own] : 16'h0001;
		sum    = {1'b0, rdv} + {17'h0_0000, inc};
		ovf_hit = sum > {1'b0, CNT_MAX};
		wdat   = ovf_hit ? CNT_MAX : sum[31:0];
		ctl_wr = {2{reg_wr && reg_addr == A_CTRL}};
		start  = ctl_wr & reg_wdata[CT_ACQ +: 2] & ~acq;
		pw     = reg_wr && reg_addr[7:6] == A_PORT;
		pp     = {reg_addr[5], ~reg_addr[5]};
		// any enabled preset ends the run
		for (int p = 0; p < 2; p++)
		begin
			stop[p] = acq[p] && ((pen[p][PE_LIVE] && live[p] >= lpre[p])
				|| (pen[p][PE_TRUE] && tru[p] >= tpre[p])
				|| (pen[p][PE_ROI] && rcnt[p] >= rpre[p])
				|| (pen[p][PE_OVF] && ovf[p]));
		end
	end

	// ----------------------------------------
	// Converter ports
	// ----------------------------------------
	// Accept, hold for the transfer time, then capture the channel
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			for (int p = 0; p < 2; p++)
			begin
				pst[p]  <= P_IDLE;
				xcnt[p] <= '0;
				chan[p] <= '0;
			end
			conv_accept <= '0;
		end
		else
		begin
			for (int p = 0; p < 2; p++)
			begin
				case (pst[p])
					P_IDLE:
					begin
						// Ready ignored while the port is not acquiring
						if (acq[p] && conv_ready[p])
						begin
							pst[p]         <= P_XFER;
							conv_accept[p] <= 1'b1;
							case (xsel[p])
								2'h0:    xcnt[p] <= 7'(XF075_CYC - 1);
								2'h1:    xcnt[p] <= 7'(XF100_CYC - 1);
								2'h2:    xcnt[p] <= 7'(XF150_CYC - 1);
								default: xcnt[p] <= 7'(XF200_CYC - 1);
							endcase
						end
					end
					P_XFER:
					begin
						if (xcnt[p] == 7'h00)
						begin
							conv_accept[p] <= 1'b0;
							chan[p] <= ~channel_bit_lsb_n[p];
							// channels past the group length are dropped
							pst[p] <= (~channel_bit_lsb_n[p] < {dpha_glen(grp[p][7:0]), 8'h00})
								? P_WAIT : P_IDLE;
						end
						else
							xcnt[p] <= xcnt[p] - 7'h01;
					end
					P_WAIT:
					begin
						if (gnt_v && gnt_p == p[0])
							pst[p] <= P_RMW;
					end
					P_RMW:
					begin
						if (mem_we && own == p[0])
							pst[p] <= P_IDLE;
					end
					default: pst[p] <= P_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Shared memory: read, add, write
	// ----------------------------------------
	// one pool serves both ports
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			busy <= 1'b0;
			own  <= 1'b0;
			mcnt <= '0;
			mwa  <= '0;
			rdv  <= '0;
		end
		else if (gnt_v)
		begin
			busy <= 1'b1;
			own  <= gnt_p;
			mcnt <= '0;
			// allocation may span the whole pool
			mwa  <= dpha_gaddr(base[gnt_p], grp[gnt_p], chan[gnt_p]);
		end
		else if (busy)
		begin
			if (mcnt == 6'h00)
				rdv <= mem[mwa];
			busy <= !mem_we;
			mcnt <= mcnt + 6'h01;
		end
	end

	// Engine write wins; a software write in that cycle is lost
	always_ff @(posedge clk)
	begin
		if (mem_we)
			mem[mwa] <= wdat;
		else if (reg_wr && reg_addr == A_MDATA)
			mem[maddr] <= reg_wdata;
	end

	// ----------------------------------------
	// Acquisition control and counters
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			acq  <= '0;
			loss_free_weighting  <= '0;
			ovf  <= '0;
			xsel <= '{XSEL_RST, XSEL_RST};
			for (int p = 0; p < 2; p++)
			begin
				live[p] <= '0;
				tru[p]  <= '0;
				rcnt[p] <= '0;
			end
		end
		else
		begin
			if (ctl_wr[0])
			begin
				loss_free_weighting     <= reg_wdata[CT_LFC +: 2];
				xsel[0] <= reg_wdata[CT_XS0 +: 2];
				xsel[1] <= reg_wdata[CT_XS1 +: 2];
			end
			for (int p = 0; p < 2; p++)
			begin
				if (ctl_wr[p])
					acq[p] <= reg_wdata[CT_ACQ + p];
				else if (stop[p])
					acq[p] <= 1'b0;
				// overflow set wins over the clear at start
				if (mem_we && ovf_hit && own == p[0])
					ovf[p] <= 1'b1;
				else if (start[p])
					ovf[p] <= 1'b0;
				if (start[p])
				begin
					live[p] <= '0;
					tru[p]  <= '0;
					rcnt[p] <= '0;
				end
				else if (acq[p])
				begin
					if (tick && pst[p] == P_IDLE)
						live[p] <= live[p] + 32'h0000_0001;
					if (tick)
						tru[p] <= tru[p] + 32'h0000_0001;
					if (mem_we && own == p[0] && chan[p] >= region_of_interest[p][15:0] && chan[p] <= region_of_interest[p][31:16])
						rcnt[p] <= rcnt[p] + {16'h0000, inc};
				end
			end
		end
	end

	// ----------------------------------------
	// Software setup registers
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			imsk  <= '0;
			maddr <= '0;
			for (int p = 0; p < 2; p++)
			begin
				base[p] <= '0;
				grp[p]  <= '0;
				wgt[p]  <= 16'h0001;
				pen[p]  <= '0;
				lpre[p] <= '0;
				tpre[p] <= '0;
				rpre[p] <= '0;
				region_of_interest[p]  <= '0;
			end
		end
		else if (reg_wr)
		begin
			if (reg_addr == A_IMASK)
				imsk <= reg_wdata[3:0];
			if (reg_addr == A_MADDR)
				maddr <= reg_wdata[15:0];
			for (int p = 0; p < 2; p++)
			begin
				if (pw && pp[p])
				begin
					case (reg_addr[4:2])
						P_BASE:  base[p] <= reg_wdata[15:0];
						P_GRP:   grp[p]  <= reg_wdata[13:0];
						P_WGT:   wgt[p]  <= reg_wdata[15:0];
						P_PEN:   pen[p]  <= reg_wdata[3:0];
						P_LIVE:  lpre[p] <= reg_wdata;
						P_TRUE:  tpre[p] <= reg_wdata;
						P_ROI:   region_of_interest[p]  <= reg_wdata;
						default: rpre[p] <= reg_wdata;
					endcase
				end
			end
		end
	end

	// ----------------------------------------
	// Interrupts, lamps, read port
	// ----------------------------------------
	// A read clears the status; a new event in that cycle survives
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			ist <= '0;
			irq <= 1'b0;
		end
		else
		begin
			ist <= ((reg_rd && reg_addr == A_ISTAT) ? 4'h0 : ist) | {
				{mem_we && ovf_hit && own, mem_we && ovf_hit && !own}, stop};
			irq <= |(ist & imsk);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			port_collecting_lamp <= '0;
			port_active_lamp     <= '0;
		end
		else
		begin
			port_collecting_lamp <= acq;
			for (int p = 0; p < 2; p++)
				port_active_lamp[p] <= conv_ready[p] || pst[p] != P_IDLE;
		end
	end

	// Unmapped reads return zero
	always_ff @(posedge clk)
	begin
		if (!resetn)
			reg_rdata <= '0;
		else if (reg_rd)
		begin
			reg_rdata <= '0;
			if (reg_addr == A_CTRL)
				reg_rdata <= {24'h00_0000, xsel[1], xsel[0], loss_free_weighting, acq};
			if (reg_addr == A_STAT)
				reg_rdata <= {28'h000_0000, acq, ovf};
			if (reg_addr == A_ISTAT)
				reg_rdata <= {28'h000_0000, ist};
			if (reg_addr == A_IMASK)
				reg_rdata <= {28'h000_0000, imsk};
			if (reg_addr == A_MADDR)
				reg_rdata <= {16'h0000, maddr};
			if (reg_addr == A_MDATA)
				reg_rdata <= mem[maddr];
			if (reg_addr[7:6] == A_PORT)
			begin
				case (reg_addr[4:2])
					P_BASE:  reg_rdata <= {16'h0000, base[reg_addr[5]]};
					P_GRP:   reg_rdata <= {18'h0_0000, grp[reg_addr[5]]};
					P_WGT:   reg_rdata <= {16'h0000, wgt[reg_addr[5]]};
					P_PEN:   reg_rdata <= {28'h000_0000, pen[reg_addr[5]]};
					P_LIVE:  reg_rdata <= lpre[reg_addr[5]];
					P_TRUE:  reg_rdata <= tpre[reg_addr[5]];
					P_ROI:   reg_rdata <= region_of_interest[reg_addr[5]];
					default: reg_rdata <= rpre[reg_addr[5]];
				endcase
			end
			if (reg_addr[7:5] == A_CNT && reg_addr[3:2] == C_LIVE)
				reg_rdata <= live[reg_addr[4]];
			if (reg_addr[7:5] == A_CNT && reg_addr[3:2] == C_TRUE)
				reg_rdata <= tru[reg_addr[4]];
			if (reg_addr[7:5] == A_CNT && reg_addr[3:2] == C_ROI)
				reg_rdata <= rcnt[reg_addr[4]];
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking dpha_cb @(posedge clk); endclocking
	default disable iff (!resetn);

	height_add_a: assert property (mem_we && !loss_free_weighting[own] && !ovf_hit |-> wdat == rdv + 32'h0000_0001)
		else $error("height mode did not add one");
	weight_add_a: assert property (mem_we && loss_free_weighting[own] && !ovf_hit |-> wdat == rdv + {16'h0000, wgt[own]})
		else $error("weighted mode did not add weight");
	mem_phase_a: assert property ($rose(busy) |-> ##38 mem_we ##1 !busy)
		else $error("memory phase length wrong");
	xfer_time_a: assert property ($rose(conv_accept[0]) && xsel[0] == 2'h1 |-> ##39 conv_accept[0] ##1 !conv_accept[0])
		else $error("1 us transfer time wrong");
	preset_stop_a: assert property (stop[1] && !ctl_wr[1] |=> !acq[1] ##1 !port_collecting_lamp[1])
		else $error("preset did not end acquisition");
	status_word_a: assert property (reg_rd && reg_addr == A_STAT |=> reg_rdata[3:0] == $past({acq, ovf}))
		else $error("status word mismatch");
	active_lamp_a: assert property (conv_accept[1] |=> port_active_lamp[1])
		else $error("activity lamp dark during transfer");
	ovf_flag_a: assert property (mem_we && ovf_hit |=> ovf[$past(own)] && mem[$past(mwa)] == CNT_MAX)
		else $error("overflow not flagged or not saturated");
	// Worked out apart from the helper: base plus select times clipped length, wrapped to 16 bits
	group_addr_a: assert property (gnt_v |=> mwa == 16'(32'(base[own]) + 32'(chan[own])
		+ 32'(grp[own][13:8]) * 32'((grp[own][7:0] > GLEN_MAX) ? GLEN_MAX : grp[own][7:0]) * 32'h0000_0100))
		else $error("group address wrong");

	height_cov: cover property (mem_we && !loss_free_weighting[own]);
	weight_cov: cover property (mem_we && loss_free_weighting[own]);
	preset_cov: cover property (stop[0]);
	both_cov:   cover property (pst[0] == P_WAIT && pst[1] == P_WAIT);

endmodule

/* dpha_conv_model.sv */
// Converter model for one port of the histogram engine.
// Assumes the bench pulses fire for one cycle while busy is low.
`timescale 1ns/1ps
module dpha_conv_model (
	input  wire logic        clk,
	input  wire logic        fire,
	input  wire logic [15:0] chan,
	input  wire logic [7:0]  lag,
	input  wire logic        accept,
	output logic             ready,
	output logic      [15:0] data_n,
	output logic             busy,
	output int               acc_len
);
	int k;                            // Bounded wait for accept

	// ----------------------------------------
	// One conversion per fire pulse
	// ----------------------------------------
	initial
	begin
		ready = 1'b0;
		data_n = 16'hFFFF;
		busy = 1'b0;
		acc_len = 0;
		forever
		begin
			@(posedge clk);
			if (fire)
			begin
				busy <= 1'b1;
				// Slow converter: lag before ready
				repeat (lag) @(posedge clk);
				data_n <= ~chan;
				ready <= 1'b1;
				for (k = 0; k < 300 && accept !== 1'b1; k++)
					@(posedge clk);
				acc_len = 0;
				// Count accept cycles; data stay put meanwhile
				while (accept === 1'b1)
				begin
					acc_len++;
					@(posedge clk);
				end
				// Hold past accept, well inside the allowed drop time
				repeat (lag) @(posedge clk);
				ready <= 1'b0;
				// Released lines float to the pull-up level
				data_n <= 16'hFFFF;
				busy <= 1'b0;
			end
		end
	end
endmodule

/* tb_top.sv */
// Bench for the two-port histogram engine: register tasks and models.
// Assumes the engine checks its own assertions inside the design files.
`timescale 1ns/1ps
module tb_top
	import dpha_pkg::*;
;
	localparam int TICKS = 20;                // Short preset tick
	logic             clk, resetn, reg_wr, reg_rd, irq;
	logic [7:0]       reg_addr;
	logic [31:0]      reg_wdata, reg_rdata, d;
	logic [1:0]       conv_accept, coll, act, fire;
	wire  [1:0]       conv_ready, busy;
	wire  [1:0][15:0] chn;                    // Active-low channel lines
	logic [15:0]      chan_q [2];
	logic [7:0]       lag_q [2];
	int               acc [2];
	int               fail_count, tests_run, span, i, k;
	int               xlen [4] = '{XF075_CYC, XF100_CYC, XF150_CYC, XF200_CYC};

	dpha_engine #(.TICK_CYCLES(TICKS)) dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.channel_bit_lsb_n(chn), .conv_ready(conv_ready), .conv_accept(conv_accept),
		.port_collecting_lamp(coll), .port_active_lamp(act), .irq(irq));

	// One converter model per port
	for (genvar g = 0; g < 2; g++)
	begin : g_conv
		dpha_conv_model m (.clk(clk), .fire(fire[g]), .chan(chan_q[g]), .lag(lag_q[g]),
			.accept(conv_accept[g]), .ready(conv_ready[g]), .data_n(chn[g]), .busy(busy[g]),
			.acc_len(acc[g]));
	end

	// 40 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] pa(input int p, input int o);
		return 8'(64 + 32 * p + o);
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
			fail_count++;
		end
	endtask

	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// The used-up busy bound in ev counts as a mismatch; the accept and span bounds do not
	task automatic hang();
		fail_count++;
		tally_and_finish();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Data land at the strobe edge and hold until the next read
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic setm(input logic [15:0] a, input logic [31:0] v);
		wr(A_MADDR, {16'h0000, a});
		wr(A_MDATA, v);
	endtask

	task automatic getm(input logic [15:0] a);
		wr(A_MADDR, {16'h0000, a});
		rd(A_MDATA);
	endtask

	// One conversion; span counts cycles from accept to idle lamp
	task automatic ev(input int p, input logic [15:0] ch, input logic [7:0] lg);
		@(posedge clk);
		chan_q[p] <= ch;
		lag_q[p] <= lg;
		fire[p] <= 1'b1;
		@(posedge clk);
		fire[p] <= 1'b0;
		for (k = 0; k < 300 && conv_accept[p] !== 1'b1; k++)
			@(posedge clk);
		for (span = 0; span < 300 && act[p] === 1'b1; span++)
			@(posedge clk);
		for (k = 0; k < 900 && busy[p] !== 1'b0; k++)
			@(posedge clk);
		if (k == 900)
			hang();
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		resetn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		fire = 2'b00;
		chan_q = '{default: 16'h0000};
		lag_q = '{default: 8'h00};
		fail_count = 0;
		tests_run = 0;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;

		rd(A_CTRL);
		chk("ctrl reset", d, 32'h0000_0050);
		rd(A_STAT);
		chk("status reset", d, 32'h0000_0000);
		rd(8'hFC);
		chk("unmapped", d, 32'h0000_0000);
		chk("lamps reset", {coll, act, irq}, 32'h0000_0000);
		$display("Test reset done");

		// Height then weighted mode, port 0, 256-channel group at base 0
		wr(pa(0, 0), 32'h0000_0000);
		wr(pa(0, 4), 32'h0000_0001);
		setm(16'h0005, 32'h0000_0000);
		ev(0, 16'h0005, 8'h00);
		chk("idle accept", acc[0], 0);
		wr(A_CTRL, 32'h0000_0051);
		rd(A_STAT);
		chk("status acq", d, 32'h0000_0004);
		chk("collect lamp", coll, 2'b01);
		ev(0, 16'h0005, 8'h00);
		chk("cycle span", (span >= 78 && span <= 84), 1'b1);
		ev(0, 16'h0005, 8'h09);
		chk("accept 1us", acc[0], XF100_CYC);
		getm(16'h0005);
		chk("height count", d, 32'h0000_0002);
		wr(pa(0, 8), 32'h0000_0007);
		wr(A_CTRL, 32'h0000_0055);
		ev(0, 16'h0005, 8'h03);
		getm(16'h0005);
		chk("weighted count", d, 32'h0000_0009);
		$display("Test modes done");

		// Groups: base 0x100, 512 channels, select 3
		wr(pa(0, 0), 32'h0000_0100);
		wr(pa(0, 4), 32'h0000_0302);
		setm(16'h08FF, 32'h0000_0000);
		setm(16'h0900, 32'h0000_0000);
		ev(0, 16'h01FF, 8'h00);
		ev(0, 16'h0200, 8'h00);
		getm(16'h08FF);
		chk("group addr", d, 32'h0000_0007);
		getm(16'h0900);
		chk("past group", d, 32'h0000_0000);
		// Last group of 32K reaches the top of the pool
		wr(pa(0, 0), 32'h0000_0000);
		wr(pa(0, 4), 32'h0000_3F80);
		setm(16'hFFFF, 32'h0000_0000);
		ev(0, 16'h7FFF, 8'h00);
		getm(16'hFFFF);
		chk("top channel", d, 32'h0000_0007);
		$display("Test groups done");

		// Overflow on port 1 with interrupt mask
		wr(pa(1, 0), 32'h0000_0000);
		wr(pa(1, 4), 32'h0000_0001);
		setm(16'h0003, 32'h7FFF_FFFF);
		wr(A_CTRL, 32'h0000_0052);
		ev(1, 16'h0003, 8'h00);
		getm(16'h0003);
		chk("saturated", d, 32'h7FFF_FFFF);
		rd(A_STAT);
		chk("status ovf", d, 32'h0000_000A);
		repeat (3) @(posedge clk);
		chk("irq masked", irq, 1'b0);
		wr(A_IMASK, 32'h0000_000C);
		repeat (3) @(posedge clk);
		chk("irq raised", irq, 1'b1);
		rd(A_ISTAT);
		chk("int status", d, 32'h0000_0008);
		repeat (3) @(posedge clk);
		chk("irq cleared", irq, 1'b0);
		$display("Test overflow done");

		// Every transfer time on port 1
		for (i = 0; i < 4; i++)
		begin
			wr(A_CTRL, 32'h12 | (i << 6));
			ev(1, 16'h0004, 8'h00);
			chk("accept len", acc[1], xlen[i]);
		end
		$display("Test transfer done");

		// Live preset on port 0, true preset on port 1
		for (i = 0; i < 2; i++)
		begin
			wr(pa(i, 12), 32'h1 << i);
			wr(pa(i, 16 + 4 * i), 32'h0000_0003);
			wr(A_IMASK, 32'h1 << i);
			wr(A_CTRL, 32'h50 | (1 << i));
			// Lamp trails acq by a cycle, so let it light first
			repeat (2) @(posedge clk);
			for (k = 0; k < 200 && coll[i] !== 1'b0; k++)
				@(posedge clk);
			chk("preset time", (k >= 40 && k <= 66), 1'b1);
			chk("preset irq", irq, 1'b1);
			rd(8'(128 + 20 * i));
			chk("tick count", d, 32'h0000_0003);
			rd(A_ISTAT);
			chk("done flag", d, 32'h1 << i);
		end
		$display("Test presets done");

		// Region preset on port 0: bounds 4..6, limit 2, one hit outside first
		wr(pa(0, 12), 32'h0000_0004);
		wr(pa(0, 24), 32'h0006_0004);
		wr(pa(0, 28), 32'h0000_0002);
		wr(A_CTRL, 32'h0000_0051);
		ev(0, 16'h0009, 8'h00);
		ev(0, 16'h0005, 8'h00);
		rd(8'h88);
		chk("roi count", d, 32'h0000_0001);
		ev(0, 16'h0004, 8'h00);
		repeat (2) @(posedge clk);
		chk("roi stop", coll[0], 1'b0);
		rd(A_ISTAT);
		chk("roi flag", d, 32'h0000_0001);
		$display("Test region done");
		tally_and_finish();
	end
endmodule
